// *** src/gpio_edge_regs.vh ***
/*
 Register offsets, field positions, reset values and timing constants for the
 I/O port with edge interrupt lines. Assumes a word-indexed register port.
*/
`ifndef GPIO_EDGE_REGS_VH
`define GPIO_EDGE_REGS_VH

// ****************************************
// sizes
// ****************************************
`define NUM_PINS        16
`define NUM_LINES       23
`define NUM_PIN_LINES   16
`define NUM_INT_LINES   7
`define ADDR_W          6

// ****************************************
// register offsets (word index)
// ****************************************
`define REG_MODE        6'h00
`define REG_OTYPE       6'h01
`define REG_PULL        6'h02
`define REG_OUT         6'h03
`define REG_IN          6'h04
`define REG_TOGGLE      6'h05
`define REG_AFSEL_LO    6'h06
`define REG_AFSEL_HI    6'h07
`define REG_LOCK        6'h08
`define REG_LINESRC_0   6'h09
`define REG_LINESRC_1   6'h0A
`define REG_ROUTE       6'h0B
`define REG_RISE        6'h0C
`define REG_FALL        6'h0D
`define REG_IMASK       6'h0E
`define REG_EMASK       6'h0F
`define REG_PEND        6'h10
`define REG_SWTRIG      6'h11
`define REG_IRQ_STAT    6'h12
`define REG_IRQ_MASK    6'h13

// ****************************************
// field encodings and reset values
// ****************************************
`define MODE_INPUT      2'h0
`define MODE_OUTPUT     2'h1
`define MODE_ALT        2'h2
`define MODE_ANALOG     2'h3
`define PULL_NONE       2'h0
`define PULL_UP         2'h1
`define PULL_DOWN       2'h2
`define MODE_RST        32'h00000000
`define LOCK_KEY        16'hA5A5
`define LOCK_BIT        16
`define IRQ_PEND_BIT    0
`define IRQ_LOCK_BIT    1
`define IRQ_W           2

// ****************************************
// timing
// ****************************************
`define CLK_MHZ         200
`define TOGGLE_MHZ      16

`endif

// *** src/edge_capture_line.v ***
/*
 One edge detector line: asynchronous capture of a short pulse, then a
 two-flop synchroniser and a one-cycle detect pulse on sys_clk.
 Assumes the raw source is unrelated to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module edge_capture_line (
	input  wire sys_clk,
	input  wire reset,
	input  wire raw_in,
	input  wire rise_en,
	input  wire fall_en,
	output reg  edge_seen
);

	// ****************************************
	// async catch by toggling flops, cleared only by reset
	// ****************************************
	reg rise_cap;
	reg fall_cap;
	reg rise_s1;
	reg rise_s2;
	reg rise_s3;
	reg fall_s1;
	reg fall_s2;
	reg fall_s3;

	// toggling capture, so pulses shorter than a clock still register
	always @(posedge raw_in or posedge reset) begin
		if (reset)
			rise_cap <= 1'b0;
		else
			rise_cap <= ~rise_cap;
	end

	always @(negedge raw_in or posedge reset) begin
		if (reset)
			fall_cap <= 1'b0;
		else
			fall_cap <= ~fall_cap;
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			rise_s1 <= 1'b0;
			rise_s2 <= 1'b0;
			rise_s3 <= 1'b0;
			fall_s1 <= 1'b0;
			fall_s2 <= 1'b0;
			fall_s3 <= 1'b0;
			edge_seen <= 1'b0;
		end else begin
			rise_s1 <= rise_cap;
			rise_s2 <= rise_s1;
			rise_s3 <= rise_s2;
			fall_s1 <= fall_cap;
			fall_s2 <= fall_s1;
			fall_s3 <= fall_s2;
			edge_seen <= (rise_en & (rise_s2 ^ rise_s3)) | (fall_en & (fall_s2 ^ fall_s3));
		end
	end

endmodule

`default_nettype wire

// *** src/gpio_edge_port.v ***
/*
 I/O port with pin configuration, alternate-function remap, lockable
 configuration, routing to timers and comparator, and 23 edge lines with
 masks, pending bits and a summary interrupt.
 Assumes a word-indexed register port on sys_clk and pins outside the domain.
*/
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_edge_regs.vh"

// Summary of operation
// - each pin is set up as push-pull or open-drain output, floating or pulled input, or alternate function.
// - each alternate function on a pin is chosen by its own remap field.
// - writing the key then the key inverted locks the alternate-function setup until reset.
// - the port is reached by the system bus and toggles outputs with a one-cycle write.
// - twenty-three edge lines each raise an interrupt or an event request.
// - each line chooses rising, falling or both edges.
// - each line has its own mask.
// - a pending bit per line records a detected interrupt request.
// - pulses narrower than a clock period are still caught.
// - sixteen lines come from pins, each picking its pin by a selector.
// - seven lines come from clock, supply detector, USB and comparator events.
// - routing selects which pins feed three timers and two comparator inputs, and enables the reference output.

module gpio_edge_port (
	input  wire                        sys_clk,
	input  wire                        reset,
	input  wire [`ADDR_W-1:0]          reg_addr,
	input  wire [31:0]                 reg_wdata,
	input  wire                        reg_write,
	input  wire                        reg_read,
	output reg  [31:0]                 reg_rdata,
	input  wire [`NUM_PINS-1:0]        pin_in,
	output reg  [`NUM_PINS-1:0]        pin_out,
	output reg  [`NUM_PINS-1:0]        pin_oe_n,
	output reg  [`NUM_PINS-1:0]        pin_pull_up,
	output reg  [`NUM_PINS-1:0]        pin_pull_down,
	output reg  [`NUM_PINS-1:0]        pin_analog,
	input  wire [`NUM_PINS-1:0]        alt_out,
	input  wire [`NUM_PINS-1:0]        alt_oe,
	output reg  [`NUM_PINS-1:0]        alt_in,
	output reg  [63:0]                 alt_select,
	input  wire [`NUM_INT_LINES-1:0]   internal_event,
	output reg  [`NUM_LINES-1:0]       line_irq,
	output reg  [`NUM_LINES-1:0]       line_event,
	output reg  [2:0]                  timer_in,
	output reg  [1:0]                  comp_in,
	output reg                         vref_out_en,
	output reg                         irq
);

	// ****************************************
	// functions
	// ****************************************
	function [3:0] nib;
		input [63:0] v;
		input [3:0]  i;
		begin
			nib = v[{i, 2'b00} +: 4];
		end
	endfunction

	function [15:0] wsel;
		input [15:0] cur;
		input [15:0] d;
		input        hit;
		begin
			wsel = hit ? d : cur;
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg  [31:0]              mode;
	reg  [15:0]              otype;
	reg  [31:0]              pull;
	reg  [15:0]              out_data;
	reg  [31:0]              afsel_lo;
	reg  [31:0]              afsel_hi;
	reg                      locked;
	reg                      key_seen;
	reg  [63:0]              line_src;
	reg  [15:0]              route;
	reg  [`NUM_LINES-1:0]    rise_en;
	reg  [`NUM_LINES-1:0]    fall_en;
	reg  [`NUM_LINES-1:0]    imask;
	reg  [`NUM_LINES-1:0]    emask;
	reg  [`NUM_LINES-1:0]    pend;
	reg  [`NUM_LINES-1:0]    sw_trig;
	reg  [`IRQ_W-1:0]        irq_stat;
	reg  [`IRQ_W-1:0]        irq_mask;
	reg  [`NUM_PINS-1:0]     pin_s1;
	reg  [`NUM_PINS-1:0]     pin_s2;
	reg  [`NUM_LINES-1:0]    raw_line;
	wire [`NUM_LINES-1:0]    edge_hit;
	reg  [`NUM_LINES-1:0]    fired;
	reg  [31:0]              next_rdata;
	reg  [15:0]              is_out;
	reg  [15:0]              is_alt;
	integer                  i;

	// ****************************************
	// write decode
	// ****************************************
	function wr_at;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] target;
		begin
			wr_at = (a == target);
		end
	endfunction

	// mode and remap writes are dropped once locked
	wire             wr_mode     = reg_write && wr_at(reg_addr, `REG_MODE) && !locked;
	wire             wr_otype    = reg_write && wr_at(reg_addr, `REG_OTYPE);
	wire             wr_pull     = reg_write && wr_at(reg_addr, `REG_PULL);
	wire             wr_out      = reg_write && wr_at(reg_addr, `REG_OUT);
	wire             wr_toggle   = reg_write && wr_at(reg_addr, `REG_TOGGLE);
	wire             wr_af_lo    = reg_write && wr_at(reg_addr, `REG_AFSEL_LO) && !locked;
	wire             wr_af_hi    = reg_write && wr_at(reg_addr, `REG_AFSEL_HI) && !locked;
	wire             wr_lock     = reg_write && wr_at(reg_addr, `REG_LOCK);
	wire             wr_src_lo   = reg_write && wr_at(reg_addr, `REG_LINESRC_0);
	wire             wr_src_hi   = reg_write && wr_at(reg_addr, `REG_LINESRC_1);
	wire             wr_route    = reg_write && wr_at(reg_addr, `REG_ROUTE);
	wire             wr_rise     = reg_write && wr_at(reg_addr, `REG_RISE);
	wire             wr_fall     = reg_write && wr_at(reg_addr, `REG_FALL);
	wire             wr_imask    = reg_write && wr_at(reg_addr, `REG_IMASK);
	wire             wr_emask    = reg_write && wr_at(reg_addr, `REG_EMASK);
	wire             wr_pend     = reg_write && wr_at(reg_addr, `REG_PEND);
	wire             wr_swtrig   = reg_write && wr_at(reg_addr, `REG_SWTRIG);
	wire             wr_irq_mask = reg_write && wr_at(reg_addr, `REG_IRQ_MASK);
	wire             rd_irq_stat = reg_read && wr_at(reg_addr, `REG_IRQ_STAT);
	wire             key_ok      = reg_wdata[15:0] == `LOCK_KEY && reg_wdata[`LOCK_BIT];
	wire             key_inv_ok  = reg_wdata[15:0] == ~`LOCK_KEY && reg_wdata[`LOCK_BIT];
	wire             lock_done   = wr_lock && !locked && key_seen && key_inv_ok;
	wire [`IRQ_W-1:0] stat_set   = {lock_done, |(fired & imask)};

	// ****************************************
	// edge line sources
	// ****************************************
	// raw pin selection feeds async capture; select changes may make a spurious edge
	always @* begin
		raw_line = {`NUM_LINES{1'b0}};
		for (i = 0; i < `NUM_PIN_LINES; i = i + 1)
			raw_line[i] = pin_in[nib(line_src, i[3:0])];
		raw_line[`NUM_LINES-1:`NUM_PIN_LINES] = internal_event;
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_LINES; g = g + 1) begin : lines
			edge_capture_line u_line (
				.sys_clk   (sys_clk),
				.reset     (reset),
				.raw_in    (raw_line[g]),
				.rise_en   (rise_en[g]),
				.fall_en   (fall_en[g]),
				.edge_seen (edge_hit[g])
			);
		end
	endgenerate

	always @* begin
		fired = edge_hit | sw_trig;
		is_out = 16'h0000;
		is_alt = 16'h0000;
		for (i = 0; i < `NUM_PINS; i = i + 1) begin
			is_out[i] = mode[2*i +: 2] == `MODE_OUTPUT;
			is_alt[i] = mode[2*i +: 2] == `MODE_ALT;
		end
	end

	// ****************************************
	// pin configuration registers
	// ****************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			mode <= `MODE_RST;
			otype <= 16'h0000;
			pull <= 32'h00000000;
			out_data <= 16'h0000;
			afsel_lo <= 32'h00000000;
			afsel_hi <= 32'h00000000;
			line_src <= 64'h0000000000000000;
			route <= 16'h0000;
		end else begin
			if (wr_mode) mode <= reg_wdata;
			if (wr_otype) otype <= reg_wdata[15:0];
			if (wr_pull) pull <= reg_wdata;
			out_data <= wsel(out_data, reg_wdata[15:0], wr_out);
			// toggle register flips outputs in one cycle, far above the 16 MHz need
			if (wr_toggle) out_data <= out_data ^ reg_wdata[15:0];
			if (wr_af_lo) afsel_lo <= reg_wdata;
			if (wr_af_hi) afsel_hi <= reg_wdata;
			if (wr_src_lo) line_src[31:0] <= reg_wdata;
			if (wr_src_hi) line_src[63:32] <= reg_wdata;
			if (wr_route) route <= reg_wdata[15:0];
		end
	end

	// ****************************************
	// configuration lock
	// ****************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			locked <= 1'b0;
			key_seen <= 1'b0;
		end else begin
			// two-step key so a stray single write cannot lock
			if (lock_done)
				locked <= 1'b1;
			if (wr_lock && !locked)
				key_seen <= key_ok;
			else if (reg_write)
				key_seen <= 1'b0;
		end
	end

	// ****************************************
	// edge line state
	// ****************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			rise_en <= 23'h000000;
			fall_en <= 23'h000000;
			imask <= 23'h000000;
			emask <= 23'h000000;
			pend <= 23'h000000;
			sw_trig <= 23'h000000;
		end else begin
			sw_trig <= 23'h000000;
			if (wr_rise) rise_en <= reg_wdata[22:0];
			if (wr_fall) fall_en <= reg_wdata[22:0];
			if (wr_imask) imask <= reg_wdata[22:0];
			if (wr_emask) emask <= reg_wdata[22:0];
			if (wr_swtrig) sw_trig <= reg_wdata[22:0];
			// set wins over a same-cycle clear; only lines enabled in imask latch
			if (wr_pend)
				pend <= (pend & ~reg_wdata[22:0]) | (fired & imask);
			else
				pend <= pend | (fired & imask);
		end
	end

	// ****************************************
	// summary interrupt status
	// ****************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
		end else begin
			if (wr_irq_mask) irq_mask <= reg_wdata[`IRQ_W-1:0];
			// a read clears, but an event in the same cycle survives it
			if (rd_irq_stat)
				irq_stat <= stat_set;
			else
				irq_stat <= irq_stat | stat_set;
		end
	end

	// ****************************************
	// pin side: synchroniser and drivers
	// ****************************************
	always @(posedge sys_clk) begin
		if (reset) begin
			pin_s1 <= 16'h0000;
			pin_s2 <= 16'h0000;
			pin_out <= 16'h0000;
			pin_oe_n <= 16'hFFFF;
			pin_pull_up <= 16'h0000;
			pin_pull_down <= 16'h0000;
			pin_analog <= 16'h0000;
			alt_in <= 16'h0000;
			alt_select <= 64'h0000000000000000;
			line_irq <= 23'h000000;
			line_event <= 23'h000000;
			timer_in <= 3'h0;
			comp_in <= 2'h0;
			vref_out_en <= 1'b0;
			irq <= 1'b0;
			reg_rdata <= 32'h00000000;
		end else begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
			for (i = 0; i < `NUM_PINS; i = i + 1) begin
				// open drain only ever drives low
				pin_out[i] <= is_alt[i] ? alt_out[i] : out_data[i];
				pin_oe_n[i] <= ~((is_out[i] & (~otype[i] | ~out_data[i])) |
					(is_alt[i] & alt_oe[i] & (~otype[i] | ~alt_out[i])));
				pin_pull_up[i] <= ~is_out[i] & (pull[2*i +: 2] == `PULL_UP);
				pin_pull_down[i] <= ~is_out[i] & (pull[2*i +: 2] == `PULL_DOWN);
				pin_analog[i] <= mode[2*i +: 2] == `MODE_ANALOG;
				alt_in[i] <= is_alt[i] & pin_s2[i];
			end
			alt_select <= {afsel_hi, afsel_lo};
			timer_in[0] <= pin_s2[nib({48'h0, route}, 4'h0)];
			timer_in[1] <= pin_s2[nib({48'h0, route}, 4'h1)];
			timer_in[2] <= pin_s2[nib({48'h0, route}, 4'h2)];
			comp_in <= {pin_s2[route[15:12]], pin_s2[route[15:12] ^ 4'h1]};
			vref_out_en <= route[15] & route[14];
			line_irq <= fired & imask;
			line_event <= fired & emask;
			irq <= |(irq_stat & irq_mask);
			reg_rdata <= reg_read ? next_rdata : 32'h00000000;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always @* begin
		case (reg_addr)
			`REG_MODE:      next_rdata = mode;
			`REG_OTYPE:     next_rdata = {16'h0000, otype};
			`REG_PULL:      next_rdata = pull;
			`REG_OUT:       next_rdata = {16'h0000, out_data};
			`REG_IN:        next_rdata = {16'h0000, pin_s2};
			`REG_AFSEL_LO:  next_rdata = afsel_lo;
			`REG_AFSEL_HI:  next_rdata = afsel_hi;
			`REG_LOCK:      next_rdata = {15'h0000, locked, 16'h0000};
			`REG_LINESRC_0: next_rdata = line_src[31:0];
			`REG_LINESRC_1: next_rdata = line_src[63:32];
			`REG_ROUTE:     next_rdata = {16'h0000, route};
			`REG_RISE:      next_rdata = {9'h000, rise_en};
			`REG_FALL:      next_rdata = {9'h000, fall_en};
			`REG_IMASK:     next_rdata = {9'h000, imask};
			`REG_EMASK:     next_rdata = {9'h000, emask};
			`REG_PEND:      next_rdata = {9'h000, pend};
			`REG_IRQ_STAT:  next_rdata = {30'h00000000, irq_stat};
			`REG_IRQ_MASK:  next_rdata = {30'h00000000, irq_mask};
			default:        next_rdata = 32'h00000000;
		endcase
	end

endmodule

`default_nettype wire

// *** testbench/gpio_edge_monitor.sv ***
/*
 Checker for the I/O port with edge lines, watching top-level ports only.
 Assumes the register port and reset of the design, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpio_edge_regs.vh"

module gpio_edge_monitor (
	input wire logic                    sys_clk,
	input wire logic                    reset,
	input wire logic [`ADDR_W-1:0]      reg_addr,
	input wire logic [31:0]             reg_wdata,
	input wire logic                    reg_write,
	input wire logic                    reg_read,
	input wire logic [31:0]             reg_rdata,
	input wire logic [`NUM_PINS-1:0]    pin_out,
	input wire logic [`NUM_PINS-1:0]    pin_oe_n,
	input wire logic [`NUM_PINS-1:0]    pin_pull_up,
	input wire logic [`NUM_PINS-1:0]    pin_pull_down,
	input wire logic [`NUM_PINS-1:0]    pin_analog,
	input wire logic [`NUM_LINES-1:0]   line_irq,
	input wire logic [`NUM_LINES-1:0]   line_event,
	input wire logic                    irq
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	chk_reset_state: assert property (disable iff (1'b0) reset |=>
		pin_oe_n == 16'hFFFF && irq == 1'b0 && line_irq == 23'h0)
		else $error("outputs not idle after reset");
	chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data outside a read answer");
	chk_unmapped_zero: assert property (reg_read && reg_addr > `REG_IRQ_MASK
		|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
	// only pins driven in both cycles, so open-drain release is not a flip
	// register then pin flop: the flip shows two cycles after the write
	chk_toggle_flip: assert property (reg_write && reg_addr == `REG_TOGGLE |-> ##2
		((pin_out ^ $past(pin_out)) & ~pin_oe_n & ~$past(pin_oe_n)) ==
		($past(reg_wdata[15:0], 2) & ~pin_oe_n & ~$past(pin_oe_n)))
		else $error("toggle write did not flip pins");
	chk_analog_float: assert property ((pin_analog & ~pin_oe_n) == 16'h0)
		else $error("analog pin driven");
	chk_pull_one: assert property ((pin_pull_up & pin_pull_down) == 16'h0)
		else $error("both pulls on one pin");
	chk_irq_pulse: assert property (|line_irq |=> (line_irq & $past(line_irq)) == 23'h0)
		else $error("line request longer than one cycle");
	chk_event_pulse: assert property (|line_event |=>
		(line_event & $past(line_event)) == 23'h0) else $error("event longer than one cycle");
	chk_irq_cause: assert property ($rose(irq) |-> $past(|line_irq) || $past(|line_irq, 2)
		|| $past(|line_irq, 3) || $past(reg_write) || $past(reg_write, 2)
		|| $past(reg_write, 3) || $past(reg_write, 4)) else $error("interrupt without cause");
	chk_irq_clear: assert property ($fell(irq) |-> $past(reg_read) || $past(reg_read, 2)
		|| $past(reg_read, 3) || $past(reg_write) || $past(reg_write, 2)
		|| $past(reg_write, 3)) else $error("interrupt dropped without access");

	cover property (|line_irq);
	cover property (|line_event);
	cover property ($rose(irq));
endmodule

bind gpio_edge_port gpio_edge_monitor i_mon (.sys_clk(sys_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
	.pin_analog(pin_analog), .line_irq(line_irq), .line_event(line_event), .irq(irq));
`default_nettype wire

// *** testbench/pin_partner.sv ***
/*
 Board model of the sixteen pins: resolves each wire from the port drive,
 an outside driver and the pull resistors. Assumes an active-low port enable and an active-high ext_en.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [15:0] pin_pull_up,
	input  wire logic [15:0] pin_pull_down,
	input  wire logic [15:0] ext_drive,
	input  wire logic [15:0] ext_en,
	output wire logic [15:0] pin_in
);
	// a floating pin reads the inverse of the port value, never a kind guess
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_drive) |
		(pin_oe_n & ~ext_en & (pin_pull_up | (~pin_pull_down & ~pin_out)));
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/*
 Self-checking bench for the I/O port with edge lines.
 Assumes the pin model and the checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpio_edge_regs.vh"

module tb;
	logic        sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0;
	logic [5:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, d;
	logic [15:0] ext_drive = 0, ext_en = 16'h0008;
	logic [6:0]  internal_event = 0;
	logic [1:0]  r;
	int          n_mismatch = 0, checks_done = 0, cyc = 0;
	wire  [31:0] reg_rdata;
	wire  [15:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_down, pin_analog;
	wire  [22:0] line_irq, line_event;
	wire  [63:0] alt_select;
	wire  [15:0] alt_in;
	wire  [2:0]  timer_in;
	wire  [1:0]  comp_in;
	wire         vref_out_en;
	wire         irq;

	always #2.5 sys_clk = ~sys_clk;
	pin_partner i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
		.pin_pull_down(pin_pull_down), .ext_drive(ext_drive), .ext_en(ext_en), .pin_in(pin_in));
	gpio_edge_port i_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .pin_analog(pin_analog),
		.alt_out(16'h0), .alt_oe(16'h0), .alt_in(alt_in), .alt_select(alt_select),
		.internal_event(internal_event), .line_irq(line_irq), .line_event(line_event),
		.timer_in(timer_in), .comp_in(comp_in), .vref_out_en(vref_out_en), .irq(irq));

	// ****************************************
	// shared tasks
	// ****************************************
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_write <= 1'b1; reg_addr <= a; reg_wdata <= v;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [5:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_read <= 1'b1; reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task rc(input logic [5:0] a, input logic [31:0] exp);
		rd(a, d);
		chk(d, exp);
	endtask
	task settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	// collects {event, request} of one line over a bounded window
	task watch(input int ln);
		r = 2'b00;
		repeat (12) begin
			@(posedge sys_clk);
			#1 r = r | {line_event[ln], line_irq[ln]};
		end
	endtask
	task pin_pulse(input int p);
		@(posedge sys_clk);
		#1 ext_drive[p] = ~ext_drive[p];
		#2 ext_drive[p] = ~ext_drive[p];
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		chk(32'(pin_oe_n), 32'hFFFF);
		chk(32'(irq), 32'h0);
		rc(`REG_MODE, `MODE_RST);
		rc(6'h3F, 32'h0);
		$display("reset test done");
	endtask
	task t_pins;
		wr(`REG_MODE, 32'h5); wr(`REG_OTYPE, 32'h2); wr(`REG_OUT, 32'h3); wr(`REG_PULL, 32'h10);
		settle;
		chk(32'(pin_oe_n & 16'h3), 32'h2);
		chk(32'(pin_out[0]), 32'h1);
		chk(32'(pin_pull_up), 32'h4);
		rd(`REG_IN, d);
		chk(d & 32'h5, 32'h5);
		wr(`REG_TOGGLE, 32'h1);
		settle;
		chk(32'(pin_out[0]), 32'h0);
		rc(`REG_OUT, 32'h2);
		$display("pin test done");
	endtask
	task t_edge;
		wr(`REG_LINESRC_0, 32'h3); wr(`REG_RISE, 32'h1); wr(`REG_FALL, 32'h0);
		wr(`REG_IMASK, 32'h1); wr(`REG_EMASK, 32'h0); wr(`REG_IRQ_MASK, 32'h1);
		pin_pulse(3);
		watch(0);
		chk(32'(r), 32'h1);
		chk(32'(irq), 32'h1);
		rc(`REG_PEND, 32'h1);
		rc(`REG_IRQ_STAT, 32'h1);
		settle;
		chk(32'(irq), 32'h0);
		wr(`REG_PEND, 32'h0);
		rc(`REG_PEND, 32'h1);
		wr(`REG_PEND, 32'h1);
		rc(`REG_PEND, 32'h0);
		wr(`REG_RISE, 32'h0); wr(`REG_FALL, 32'h1); wr(`REG_EMASK, 32'h1);
		@(posedge sys_clk) ext_drive[3] <= 1'b1;
		settle;
		pin_pulse(3);
		watch(0);
		chk(32'(r), 32'h3);
		wr(`REG_RISE, 32'h1);
		repeat (2) begin
			@(posedge sys_clk) ext_drive[3] <= ~ext_drive[3];
			watch(0);
			chk(32'(r), 32'h3);
		end
		wr(`REG_PEND, 32'h1);
		rd(`REG_IRQ_STAT, d);
		$display("edge test done");
	endtask
	task t_mask;
		wr(`REG_IMASK, 32'h0); wr(`REG_EMASK, 32'h0);
		@(posedge sys_clk) ext_drive[3] <= ~ext_drive[3];
		watch(0);
		chk(32'(r), 32'h0);
		rc(`REG_PEND, 32'h0);
		wr(`REG_RISE, 32'h10000); wr(`REG_IMASK, 32'h10000);
		@(posedge sys_clk);
		#1 internal_event[0] = 1'b1;
		#2 internal_event[0] = 1'b0;
		watch(16);
		chk(32'(r), 32'h1);
		rc(`REG_PEND, 32'h10000);
		wr(`REG_PEND, 32'h10000);
		rd(`REG_IRQ_STAT, d);
		$display("mask test done");
	endtask
	task t_route;
		@(posedge sys_clk) ext_drive[3] <= 1'b1;
		wr(`REG_ROUTE, 32'hC023);
		settle;
		chk(32'(timer_in), 32'h3);
		chk(32'(comp_in), 32'h3);
		chk(32'(vref_out_en), 32'h1);
		wr(`REG_MODE, 32'h85);
		settle;
		chk(32'(alt_in), 32'h8);
		wr(`REG_MODE, 32'h5);
		$display("route test done");
	endtask
	task t_lock;
		wr(`REG_AFSEL_LO, 32'h21);
		rc(`REG_AFSEL_LO, 32'h21);
		chk(32'(alt_select[7:0]), 32'h21);
		wr(`REG_LOCK, 32'h1A5A5); wr(`REG_OUT, 32'h2); wr(`REG_LOCK, 32'h15A5A);
		rd(`REG_LOCK, d);
		chk(d & 32'h10000, 32'h0);
		wr(`REG_LOCK, 32'h1A5A5); wr(`REG_LOCK, 32'h15A5A);
		rd(`REG_LOCK, d);
		chk(d & 32'h10000, 32'h10000);
		chk(32'(irq), 32'h0);
		rd(`REG_IRQ_STAT, d);
		chk(d & 32'h2, 32'h2);
		wr(`REG_AFSEL_LO, 32'h0); wr(`REG_MODE, 32'h0);
		rc(`REG_AFSEL_LO, 32'h21);
		rc(`REG_MODE, 32'h5);
		$display("lock test done");
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude;
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset;
		t_pins;
		t_edge;
		t_mask;
		t_route;
		t_lock;
		conclude;
	end
endmodule
`default_nettype wire
